// ---- hdl/ispi_slave.sv ----
// ispi_slave: two-wire pointer slave; bus logic on link_clk, register bank port on core_clk.
// assumes a bank whose bank_valid and bank_rdata follow bank_addr combinationally.
`timescale 1ns/1ps
`default_nettype none
module ispi_slave
  import ispi_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = DEF_SLAVE_ADDR
) (
  // clocks and reset
  input wire logic core_clk,
  input wire logic link_clk,
  input wire logic rst_b,
  // bus
  ispi_bus_if.slave bus,
  // register bank, core_clk domain
  output logic [7:0] bank_addr,
  output logic bank_we,
  output logic [7:0] bank_wdata,
  input wire logic [7:0] bank_rdata,
  input wire logic bank_valid,
  // status, link_clk domain
  output logic hs_mode
);

  typedef enum logic [5:0] {
    L_IDLE = 6'b000001,
    L_ADDR = 6'b000010,
    L_ACK = 6'b000100,
    L_RX = 6'b001000,
    L_TX = 6'b010000,
    L_MACK = 6'b100000
  } ispi_lstate_t;

  typedef struct packed {
    ispi_lstate_t st;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic scl_a;
    logic sda_a;
    logic scl_f;
    logic sda_f;
    logic [1:0] scl_n;
    logic [1:0] sda_n;
    logic scl_p;
    logic [DLY_FS_CYC:0] sda_d;
    logic hs;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic first;
    logic ack;
    logic ack_rsp;
    logic drive;
    logic [3:0] quiet;
    logic [7:0] ptr;
    logic req_tgl;
    logic pend;
    logic [7:0] req_addr;
    logic [7:0] req_wdata;
    logic req_wr;
    logic [2:0] ans_s;
    logic ans_a;
    logic rsp_ok;
    logic [7:0] rsp_data;
  } ispi_link_t;

  typedef struct packed {
    logic [2:0] req_s;
    logic req_a;
    logic look;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic rsp_ok;
    logic [7:0] rsp_data;
    logic ans_tgl;
  } ispi_core_t;

  ispi_link_t l;
  ispi_link_t next_l;
  ispi_core_t c;
  ispi_core_t next_c;

  // returns {filtered, count}; a change must persist lim samples
  function automatic logic [2:0] spike_filt(input logic acc, input logic f,
                                            input logic [1:0] n, input logic [1:0] lim);
    logic [2:0] res;
    res = {f, 2'h0};
    if (acc != f) begin
      if (({1'b0, n} + 3'h1) >= {1'b0, lim}) begin
        res = {acc, 2'h0};
      end else begin
        res = {f, n + 2'h1};
      end
    end
    return res;
  endfunction

  logic [1:0] lim;
  logic sda_cur;
  logic sda_prv;
  logic start_c;
  logic stop_c;
  logic rise;
  logic fall;
  logic answered;
  logic [7:0] rx_byte;

  assign lim = l.hs ? 2'(SPIKE_HS_CYC) : 2'(SPIKE_FS_CYC);
  assign sda_cur = l.hs ? l.sda_d[DLY_HS_CYC - 1] : l.sda_d[DLY_FS_CYC - 1];
  assign sda_prv = l.hs ? l.sda_d[DLY_HS_CYC] : l.sda_d[DLY_FS_CYC];
  // delayed sda edges while scl high; delay is 160ns class in full speed, covering the 120ns bridge,
  // 80ns class (90ns) in fast mode, short of it; no 300ns hold is offered [RULE_18] [RULE_19] [RULE_20]
  assign start_c = l.scl_f && sda_prv && !sda_cur;
  assign stop_c = l.scl_f && !sda_prv && sda_cur && (l.quiet == 4'h0);
  assign rise = l.scl_f && !l.scl_p;
  assign fall = !l.scl_f && l.scl_p;
  assign answered = (l.ans_s[1] == l.ans_s[2]) && (l.ans_s[2] != l.ans_a);
  assign rx_byte = {l.sh[6:0], l.sda_f};

  always_comb begin
    next_l = l;
    // three-stage pin sync, value taken when stages two and three agree
    next_l.scl_s = {l.scl_s[1:0], bus.scl};
    next_l.sda_s = {l.sda_s[1:0], bus.sda};
    if (l.scl_s[1] == l.scl_s[2]) begin
      next_l.scl_a = l.scl_s[2];
    end
    if (l.sda_s[1] == l.sda_s[2]) begin
      next_l.sda_a = l.sda_s[2];
    end
    {next_l.scl_f, next_l.scl_n} = spike_filt(l.scl_a, l.scl_f, l.scl_n, lim); // [RULE_17]
    {next_l.sda_f, next_l.sda_n} = spike_filt(l.sda_a, l.sda_f, l.sda_n, lim); // [RULE_17]
    next_l.scl_p = l.scl_f;
    next_l.sda_d = {l.sda_d[DLY_FS_CYC - 1:0], l.sda_f};
    next_l.ans_s = {l.ans_s[1:0], c.ans_tgl};
    if (l.ans_s[1] == l.ans_s[2]) begin
      next_l.ans_a = l.ans_s[2];
    end
    if (answered) begin
      next_l.pend = 1'b0;
      next_l.rsp_ok = c.rsp_ok;
      next_l.rsp_data = c.rsp_data;
      if (l.ack_rsp) begin
        next_l.ack = c.rsp_ok; // ack follows location validity [RULE_06] [RULE_07] [RULE_22]
      end
    end
    if (stop_c) begin
      next_l.st = L_IDLE;
      next_l.drive = 1'b0;
      next_l.hs = 1'b0; // full-speed settings return at once on stop [RULE_16]
    end else if (start_c) begin
      // any start, repeated or not, restarts address reception [RULE_13]
      next_l.st = L_ADDR;
      next_l.cnt = 4'h0;
      next_l.drive = 1'b0;
    end else begin
      case (l.st)
        L_IDLE: begin
          next_l.drive = 1'b0;
        end
        L_ADDR: begin
          if (rise) begin
            next_l.sh = rx_byte; // msb first [RULE_03]
            next_l.cnt = l.cnt + 4'h1;
            if (l.cnt == 4'h7) begin
              next_l.cnt = 4'h0;
              if (rx_byte[7:1] == SLAVE_ADDR) begin
                // address match, direction in bit 0 [RULE_04] [RULE_05]
                next_l.st = L_ACK;
                next_l.rw = rx_byte[0];
                next_l.first = 1'b1;
                next_l.ack = 1'b1;
                next_l.ack_rsp = 1'b0;
                if (rx_byte[0] && !l.pend) begin
                  // prefetch from the pointer left by earlier transfers [RULE_09]
                  next_l.req_tgl = !l.req_tgl;
                  next_l.pend = 1'b1;
                  next_l.req_addr = l.ptr;
                  next_l.req_wr = 1'b0;
                end
              end else begin
                // master code: never acknowledged, fast settings right away [RULE_14] [RULE_15]
                if ((rx_byte & MASTER_CODE_MASK) == MASTER_CODE) begin
                  next_l.hs = 1'b1;
                end
                next_l.st = L_IDLE;
              end
            end
          end
        end
        L_RX: begin
          if (rise) begin
            next_l.sh = rx_byte; // msb first [RULE_03]
            next_l.cnt = l.cnt + 4'h1;
            if (l.cnt == 4'h7) begin
              next_l.cnt = 4'h0;
              next_l.st = L_ACK; // every received byte gets an acknowledge slot [RULE_01]
              next_l.ack = 1'b0;
              next_l.ack_rsp = !l.pend;
              if (!l.pend) begin
                next_l.req_tgl = !l.req_tgl;
                next_l.pend = 1'b1;
                next_l.req_wdata = rx_byte;
                if (l.first) begin
                  // pointer byte: load and look up validity [RULE_06]
                  next_l.ptr = rx_byte;
                  next_l.first = 1'b0;
                  next_l.req_addr = rx_byte;
                  next_l.req_wr = 1'b0;
                end else begin
                  // store attempt; pointer steps and wraps either way [RULE_07] [RULE_08] [RULE_11]
                  next_l.req_addr = l.ptr;
                  next_l.req_wr = 1'b1;
                  next_l.ptr = l.ptr + 8'h01;
                end
              end else if (!l.first) begin
                next_l.ptr = l.ptr + 8'h01; // [RULE_08]
              end
            end
          end
        end
        L_ACK: begin
          // start driving only in the scl low phase, never in a high phase
          if (l.cnt == 4'h1 && !l.scl_f && next_l.ack && !next_l.pend) begin
            next_l.drive = 1'b1; // [RULE_05] [RULE_01]
          end
          if (fall) begin
            if (l.cnt == 4'h0) begin
              next_l.cnt = 4'h1;
            end else begin
              next_l.cnt = 4'h0;
              next_l.drive = 1'b0;
              if (l.rw) begin
                next_l.st = L_TX;
                next_l.sh = l.rsp_data;
                next_l.drive = !l.rsp_data[7]; // [RULE_03]
              end else begin
                next_l.st = L_RX;
              end
            end
          end
        end
        L_TX: begin
          if (rise) begin
            next_l.cnt = l.cnt + 4'h1;
            if (l.cnt == 4'h7) begin
              next_l.ptr = l.ptr + 8'h01; // [RULE_08] [RULE_11]
              if (!l.pend) begin
                next_l.req_tgl = !l.req_tgl;
                next_l.pend = 1'b1;
                next_l.req_addr = l.ptr + 8'h01;
                next_l.req_wr = 1'b0;
              end
            end
          end
          if (fall) begin
            if (l.cnt == 4'h8) begin
              next_l.drive = 1'b0; // release for the master's acknowledge
              next_l.st = L_MACK;
              next_l.cnt = 4'h0;
            end else begin
              next_l.sh = {l.sh[6:0], 1'b0};
              next_l.drive = !l.sh[6]; // [RULE_03]
            end
          end
        end
        L_MACK: begin
          if (rise) begin
            if (l.sda_f) begin
              next_l.st = L_IDLE; // nack ends the read, sda stays released [RULE_02] [RULE_12]
            end else begin
              next_l.cnt = 4'h1;
            end
          end
          if (fall && l.cnt == 4'h1) begin
            // master acked: keep sending the next byte [RULE_12]
            next_l.st = L_TX;
            next_l.cnt = 4'h0;
            next_l.sh = l.rsp_data;
            next_l.drive = !l.rsp_data[7];
          end
        end
        default: begin
          next_l.st = L_IDLE;
          next_l.drive = 1'b0;
        end
      endcase
    end
    // own release reaches the delayed sda late, maybe once scl is back high; a stop
    // seen then would drop fast mode in the middle of a transfer [RULE_16]
    if (l.drive && !next_l.drive) begin
      next_l.quiet = QUIET_CYC;
    end else if (l.quiet != 4'h0) begin
      next_l.quiet = l.quiet - 4'h1;
    end
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      l <= '0;
      l.st <= L_IDLE;
      l.scl_s <= 3'b111;
      l.sda_s <= 3'b111;
      l.scl_a <= 1'b1;
      l.sda_a <= 1'b1;
      l.scl_f <= 1'b1;
      l.sda_f <= 1'b1;
      l.scl_p <= 1'b1;
      l.sda_d <= '1;
      l.ptr <= PTR_RESET;
    end else begin
      l <= next_l;
    end
  end

  // bank side: request toggle crosses in, answer toggle crosses back
  always_comb begin
    next_c = c;
    next_c.we = 1'b0;
    next_c.req_s = {c.req_s[1:0], l.req_tgl};
    if (c.req_s[1] == c.req_s[2]) begin
      next_c.req_a = c.req_s[2];
    end
    if (c.look) begin
      next_c.look = 1'b0;
      next_c.rsp_ok = bank_valid; // [RULE_22]
      next_c.rsp_data = (bank_valid && !c.wr) ? bank_rdata : 8'h00; // [RULE_10]
      next_c.we = c.wr && bank_valid; // [RULE_07]
      next_c.ans_tgl = !c.ans_tgl;
    end else if ((c.req_s[1] == c.req_s[2]) && (c.req_s[2] != c.req_a)) begin
      // payload is held by the link side until the answer returns
      next_c.look = 1'b1;
      next_c.addr = l.req_addr;
      next_c.wr = l.req_wr;
      next_c.wdata = l.req_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      c <= '0;
    end else begin
      c <= next_c;
    end
  end

  assign bank_addr = c.addr;
  assign bank_we = c.we;
  assign bank_wdata = c.wdata;
  assign hs_mode = l.hs;
  // open drain, low only; scl has no driver on this side at all [RULE_21]
  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe = l.drive;

endmodule
`default_nettype wire

// ---- hdl/ispi_pkg.sv ----
// ispi_pkg: shared constants and command codes for the two-wire pointer slave and its master.
// assumes the slave's link logic runs on a 30 ns link clock and the master on core_clk.
// Behaviour
// (RULE_01) receiver acknowledges each byte, ninth clock
// (RULE_02) master nacks last read byte, slave releases
// (RULE_03) bytes shift most significant bit first
// (RULE_04) first byte: 7-bit address plus direction
// (RULE_05) slave acknowledges its matching address byte
// (RULE_06) first written byte loads pointer, ack if valid
// (RULE_07) invalid-location writes dropped and not acknowledged
// (RULE_08) pointer increments after every data byte
// (RULE_09) reads start at current pointer value
// (RULE_10) invalid-location reads return zero byte
// (RULE_11) pointer wraps from highest to lowest
// (RULE_12) slave keeps sending until master nacks
// (RULE_13) repeated start begins new transfer
// (RULE_14) master code entry always followed by nack
// (RULE_15) switch to fast settings after master code
// (RULE_16) fast mode until stop, then restore
// (RULE_17) spike filter 10ns fast, 50ns full speed
// (RULE_18) sda hold 80ns fast, 160ns full speed
// (RULE_19) sda delayed 120ns before start/stop detection; fast mode delays only 90ns
// (RULE_20) no 300ns hold; master must supply it
// (RULE_21) slave never holds scl low
// (RULE_22) validity and data via internal bank port
package ispi_pkg;

  // clock periods
  localparam int CORE_CLK_NS = 10;
  localparam int LINK_CLK_NS = 30;

  // spike suppression, least times, rounded up
  localparam int SPIKE_FS_NS = 50;
  localparam int SPIKE_HS_NS = 10;
  localparam int SPIKE_FS_RAW = (SPIKE_FS_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;
  localparam int SPIKE_HS_RAW = (SPIKE_HS_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;
  localparam int SPIKE_FS_CYC = (SPIKE_FS_RAW < 1) ? 1 : SPIKE_FS_RAW;
  localparam int SPIKE_HS_CYC = (SPIKE_HS_RAW < 1) ? 1 : SPIKE_HS_RAW;

  // sda delay / hold for start and stop detection
  localparam int SDA_DLY_NS = 120;
  localparam int HOLD_FS_NS = 160;
  localparam int HOLD_FS_MAX_NS = 250;
  localparam int HOLD_HS_NS = 80;
  localparam int HOLD_HS_MAX_NS = 150;
  localparam int DLY_FS_NS = (SDA_DLY_NS > HOLD_FS_NS) ? SDA_DLY_NS : HOLD_FS_NS;
  localparam int DLY_FS_CYC = (DLY_FS_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;
  localparam int DLY_HS_CYC = (HOLD_HS_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;

  // master quarter-bit lengths in core_clk cycles
  localparam logic [7:0] MST_QTR_FS = 8'h28;
  localparam logic [7:0] MST_QTR_HS = 8'h14;

  // protocol values
  localparam logic [7:0] MASTER_CODE = 8'h08;
  localparam logic [7:0] MASTER_CODE_MASK = 8'hf8;
  // arbitrary neutral default slave address
  localparam logic [6:0] DEF_SLAVE_ADDR = 7'h2a;
  localparam logic [7:0] PTR_RESET = 8'h00;
  // link cycles in which a rising delayed sda after the slave's own release is no stop
  localparam logic [3:0] QUIET_CYC = 4'he;

  // master byte-level commands
  typedef enum logic [2:0] {
    ISPI_CMD_START = 3'h0,
    ISPI_CMD_STOP = 3'h1,
    ISPI_CMD_WRITE = 3'h2,
    ISPI_CMD_READ = 3'h3,
    ISPI_CMD_HS = 3'h4
  } ispi_cmd_t;

endpackage

// ---- hdl/ispi_bus_if.sv ----
// ispi_bus_if: the two-wire bus between master and slave.
// assumes open-drain sda with a pull-up; scl is driven by the master alone.
`timescale 1ns/1ps
`default_nettype none
interface ispi_bus_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic sda;

  // wired-and with pull-up
  assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

  modport master (
    output scl,
    output m_sda_o,
    output m_sda_oe,
    input sda
  );

  modport slave (
    input scl,
    input sda,
    output s_sda_o,
    output s_sda_oe
  );
endinterface
`default_nettype wire

// ---- hdl/ispi_master.sv ----
// ispi_master: byte-level bus master, scl derived from core_clk by a quarter-bit divider.
// assumes one command at a time; user sequences start, bytes, stop.
`timescale 1ns/1ps
`default_nettype none
module ispi_master
  import ispi_pkg::*;
#(
  parameter logic [7:0] QTR_FS = MST_QTR_FS,
  parameter logic [7:0] QTR_HS = MST_QTR_HS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // bus
  ispi_bus_if.master bus,
  // command side
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire ispi_cmd_t cmd_op,
  input wire logic [7:0] cmd_data,
  // response side
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_ack,
  output logic hs_mode
);

  typedef enum logic [3:0] {
    M_IDLE = 4'b0001,
    M_START = 4'b0010,
    M_BYTE = 4'b0100,
    M_STOP = 4'b1000
  } ispi_mstate_t;

  typedef struct packed {
    ispi_mstate_t st;
    logic [1:0] q;
    logic [7:0] tick;
    logic [3:0] bitn;
    logic [8:0] tx;
    logic [8:0] rx;
    logic mc;
    logic hs;
    logic scl;
    logic sda;
    logic [2:0] sda_s;
    logic sda_a;
    logic rsp_v;
    logic [7:0] rsp_data;
    logic rsp_ack;
  } ispi_mst_t;

  ispi_mst_t r;
  ispi_mst_t next_r;
  logic [7:0] qtr;
  logic tick_end;
  logic [8:0] rx_new;

  assign qtr = r.hs ? QTR_HS : QTR_FS;
  assign tick_end = (r.tick == qtr - 8'h01);
  assign rx_new = {r.rx[7:0], r.sda_a};

  always_comb begin
    next_r = r;
    next_r.rsp_v = 1'b0;
    next_r.sda_s = {r.sda_s[1:0], bus.sda};
    if (r.sda_s[1] == r.sda_s[2]) begin
      next_r.sda_a = r.sda_s[2];
    end
    if (r.st != M_IDLE) begin
      next_r.tick = tick_end ? 8'h00 : r.tick + 8'h01;
    end
    case (r.st)
      M_IDLE: begin
        next_r.tick = 8'h00;
        next_r.q = 2'h0;
        if (cmd_valid) begin
          case (cmd_op)
            ISPI_CMD_START: begin
              next_r.st = M_START;
              next_r.sda = 1'b1;
            end
            ISPI_CMD_STOP: begin
              next_r.st = M_STOP;
              next_r.sda = 1'b0;
            end
            ISPI_CMD_WRITE: begin
              next_r.st = M_BYTE;
              next_r.tx = {cmd_data, 1'b1};
              next_r.bitn = 4'h0;
              next_r.mc = 1'b0;
            end
            ISPI_CMD_READ: begin
              // cmd_data[0] set: nack this byte to end the read [RULE_02]
              next_r.st = M_BYTE;
              next_r.tx = {8'hff, cmd_data[0]};
              next_r.bitn = 4'h0;
              next_r.mc = 1'b0;
            end
            ISPI_CMD_HS: begin
              next_r.st = M_BYTE;
              next_r.tx = {MASTER_CODE, 1'b1};
              next_r.bitn = 4'h0;
              next_r.mc = 1'b1;
            end
            default: begin
              next_r.st = M_IDLE;
            end
          endcase
        end
      end
      M_START: begin
        // also serves as repeated start from scl low [RULE_13]
        if (tick_end) begin
          next_r.q = r.q + 2'h1;
          case (r.q)
            2'h0: next_r.scl = 1'b1;
            2'h1: next_r.sda = 1'b0;
            2'h2: next_r.scl = 1'b0;
            default: next_r.st = M_IDLE;
          endcase
        end
      end
      M_STOP: begin
        if (tick_end) begin
          next_r.q = r.q + 2'h1;
          case (r.q)
            2'h0: next_r.scl = 1'b1;
            2'h1: next_r.sda = 1'b1;
            2'h2: next_r.hs = 1'b0; // back to full speed on stop [RULE_16]
            default: next_r.st = M_IDLE;
          endcase
        end
      end
      M_BYTE: begin
        if (tick_end) begin
          next_r.q = r.q + 2'h1;
          case (r.q)
            // data changes a full quarter after scl falls: the slave has no hold [RULE_20]
            2'h0: next_r.sda = r.tx[8];
            2'h1: next_r.scl = 1'b1;
            2'h2: next_r.scl = 1'b1;
            default: begin
              // msb first, ninth clock carries the acknowledge [RULE_03] [RULE_01]
              next_r.rx = rx_new;
              next_r.scl = 1'b0;
              next_r.tx = {r.tx[7:0], 1'b1};
              next_r.bitn = r.bitn + 4'h1;
              if (r.bitn == 4'h8) begin
                next_r.st = M_IDLE;
                next_r.rsp_v = 1'b1;
                next_r.rsp_data = rx_new[8:1];
                next_r.rsp_ack = !rx_new[0];
                // master code is never acknowledged; enter fast mode on its nack [RULE_14]
                if (r.mc && rx_new[0]) begin
                  next_r.hs = 1'b1;
                end
              end
            end
          endcase
        end
      end
      default: begin
        next_r.st = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
      r.st <= M_IDLE;
      r.scl <= 1'b1;
      r.sda <= 1'b1;
      r.sda_s <= 3'b111;
      r.sda_a <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign cmd_ready = (r.st == M_IDLE);
  assign bus.scl = r.scl;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe = !r.sda;
  assign rsp_valid = r.rsp_v;
  assign rsp_data = r.rsp_data;
  assign rsp_ack = r.rsp_ack;
  assign hs_mode = r.hs;

endmodule
`default_nettype wire

// ---- tb/ispi_checker.sv ----
// ispi_checker: wire-level checks on the slave side of the link.
// assumes it watches the one bus that joins master and slave.
`timescale 1ns/1ps
`default_nettype none
module ispi_checker (
  // link clock and reset
  input wire logic link_clk,
  input wire logic rst_b,
  // bus and status
  input wire logic scl,
  input wire logic sda,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic hs_mode
);
  logic [4:0] stop_age;
  // cycles since the last stop; saturates so it never wraps
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      stop_age <= 5'h1f;
    end else if (scl && $past(scl) && $rose(sda)) begin
      stop_age <= 5'h00;
    end else if (stop_age != 5'h1f) begin
      stop_age <= stop_age + 5'h01;
    end
  end
  default clocking @(posedge link_clk); endclocking
  default disable iff (!rst_b);
  a_sda_steady_high: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
    else $error("slave sda moved in scl high");
  a_sda_open_drain: assert property (s_sda_oe |-> !s_sda_o)
    else $error("slave drives sda high");
  a_addr_quiet: assert property (scl && $fell(sda) && !s_sda_oe |=> !s_sda_oe [*8])
    else $error("slave drives during address");
  a_hold_after_fall: assert property ($fell(scl) |-> $stable(s_sda_oe) [*3])
    else $error("slave sda too soon after scl fall");
  a_hs_exit: assert property (scl && $past(scl) && $rose(sda) |-> ##[0:16] !hs_mode)
    else $error("fast mode kept after stop");
  a_hs_stays_on: assert property ($fell(hs_mode) |-> stop_age <= 5'h10)
    else $error("fast mode left without stop");
  a_hs_code_nack: assert property ($rose(hs_mode) |-> !s_sda_oe)
    else $error("master code acknowledged");
  a_ack_in_low: assert property ($rose(s_sda_oe) |-> !scl && !$past(scl, 2))
    else $error("slave drive outside low phase");
endmodule
`default_nettype wire

// ---- tb/i2c_slave_pointer_hs_interface_bench.sv ----
// bench: master and slave on one bus, register bank modelled here.
// assumes design defaults for quarter lengths and slave address.
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_pointer_hs_interface_bench;
  import ispi_pkg::*;
  logic core_clk, link_clk, rst_b, cmd_valid, cmd_ready, rsp_valid, rsp_ack;
  logic m_hs, s_hs, bank_we, bank_valid;
  ispi_cmd_t cmd_op;
  logic [7:0] cmd_data, rsp_data, bank_addr, bank_wdata, bank_rdata, ptr;
  logic [7:0] mem [256];
  logic [7:0] expm [256];
  logic [8:0] notes [$];
  int failures, checks_done;
  ispi_bus_if bus ();
  ispi_master i_ispi_master (.core_clk(core_clk), .rst_b(rst_b), .bus(bus),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack), .hs_mode(m_hs));
  ispi_slave i_ispi_slave (.core_clk(core_clk), .link_clk(link_clk), .rst_b(rst_b),
    .bus(bus), .bank_addr(bank_addr), .bank_we(bank_we), .bank_wdata(bank_wdata),
    .bank_rdata(bank_rdata), .bank_valid(bank_valid), .hs_mode(s_hs));
  ispi_checker i_ispi_checker (.link_clk(link_clk), .rst_b(rst_b), .scl(bus.scl),
    .sda(bus.sda), .s_sda_o(bus.s_sda_o), .s_sda_oe(bus.s_sda_oe), .hs_mode(s_hs));
  // bank holes in the middle so the pointer wraps through valid space
  function automatic logic ok(input logic [7:0] a);
    return a < 8'h08 || a > 8'hfb;
  endfunction
  assign bank_valid = ok(bank_addr);
  // holes answer non-zero so a zero read proves the slave masks them
  assign bank_rdata = bank_valid ? mem[bank_addr] : ~bank_addr;
  always @(posedge core_clk) if (bank_we) mem[bank_addr] <= bank_wdata;
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end
  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [8:0] seen, input logic [8:0] want);
    checks_done++;
    if (seen !== want) begin
      failures++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  always @(negedge core_clk) begin
    if (rsp_valid === 1'b1) begin
      chk({rsp_ack, rsp_data}, notes.size() != 0 ? notes.pop_front() : 'x);
    end
  end
  task automatic cmd(input ispi_cmd_t op, input logic [7:0] d);
    @(negedge core_clk);
    while (cmd_ready !== 1'b1) @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = d;
    @(negedge core_clk);
    cmd_valid = 1'b0;
  endtask
  task automatic put(input logic [7:0] d, input logic ack);
    notes.push_back({ack, d});
    cmd(ISPI_CMD_WRITE, d);
  endtask
  task automatic wr(input logic [7:0] p, input int n);
    logic [7:0] d;
    cmd(ISPI_CMD_START, 8'h00);
    put({DEF_SLAVE_ADDR, 1'b0}, 1'b1);
    put(p, ok(p));
    ptr = p;
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      put(d, ok(ptr));
      if (ok(ptr)) expm[ptr] = d;
      ptr++;
    end
  endtask
  task automatic rd(input int n);
    cmd(ISPI_CMD_START, 8'h00);
    put({DEF_SLAVE_ADDR, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      notes.push_back({i != n - 1, ok(ptr) ? expm[ptr] : 8'h00});
      cmd(ISPI_CMD_READ, {7'h00, i == n - 1});
      ptr++;
    end
  endtask
  initial begin
    rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = ISPI_CMD_START;
    cmd_data = 8'h00;
    failures = 0;
    checks_done = 0;
    void'($urandom(32'h37d0));
    for (int a = 0; a < 256; a++) begin
      mem[a] = 8'($urandom);
      expm[a] = mem[a];
    end
    repeat (6) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (20) @(negedge core_clk);
    ptr = PTR_RESET;
    rd(2);
    cmd(ISPI_CMD_STOP, 8'h00);
    cmd(ISPI_CMD_START, 8'h00);
    put({DEF_SLAVE_ADDR ^ 7'h15, 1'b0}, 1'b0);
    cmd(ISPI_CMD_STOP, 8'h00);
    wr(8'hfd, 5);
    rd(3);
    cmd(ISPI_CMD_STOP, 8'h00);
    wr(8'h06, 4);
    wr(8'h80, 1);
    wr(8'hfd, 0);
    rd(6);
    wr(8'h06, 0);
    rd(4);
    cmd(ISPI_CMD_STOP, 8'h00);
    cmd(ISPI_CMD_START, 8'h00);
    notes.push_back({1'b0, MASTER_CODE});
    cmd(ISPI_CMD_HS, MASTER_CODE);
    wr(8'h02, 2);
    chk({m_hs, 7'h00, s_hs}, 9'h101);
    rd(2);
    cmd(ISPI_CMD_STOP, 8'h00);
    repeat (100) @(negedge core_clk);
    chk({m_hs, 7'h00, s_hs}, 9'h000);
    chk({1'b0, mem[8'h08]}, {1'b0, expm[8'h08]});
    chk(9'(notes.size()), 9'h000);
    complete_run();
  end
  // longest run is about 50 bytes of 1440 cycles each
  initial begin
    #950000;
    failures++;
    complete_run();
  end
endmodule
`default_nettype wire
